// ==== shared/aoc_params.svh ====
`ifndef AOC_PARAMS_SVH
`define AOC_PARAMS_SVH
// Register word offsets (byte addresses)
`define AOC_ADDR_UNIT     8'h00
`define AOC_ADDR_CHCFG    8'h04
`define AOC_ADDR_SCALE_HI 8'h08
`define AOC_ADDR_SCALE_LO 8'h0c
`define AOC_ADDR_FAULTV   8'h10
`define AOC_ADDR_IDLEV    8'h14
`define AOC_ADDR_CMD      8'h18
`define AOC_ADDR_OUT      8'h1c
`define AOC_ADDR_STATUS   8'h20
// Unit register fields
`define AOC_UNIT_SC_EN    0
`define AOC_UNIT_FMT_LSB  1
`define AOC_UNIT_SWCTL    3
// Channel config fields
`define AOC_CH_RANGE_LSB  0
`define AOC_CH_UL_EN      3
`define AOC_CH_LL_EN      4
`define AOC_CH_FAULT_EN   5
`define AOC_CH_IDLE_EN    6
// Reset values and scale code bounds
`define AOC_SCALE_HI_RST  16'sh03e8
`define AOC_SCALE_LO_RST  16'sh0000
`define AOC_SCALE_MAX     16'sh7fff
`define AOC_SCALE_MIN     16'sh8001
// Range ends in hundredths of a volt or milliamp
`define AOC_END_0V        16'sh0000
`define AOC_END_1V        16'sh0064
`define AOC_END_4MA       16'sh0190
`define AOC_END_5V        16'sh01f4
`define AOC_END_10V       16'sh03e8
`define AOC_END_20MA      16'sh07d0
`endif

// ==== shared/aoc_pkg.sv ====
`default_nettype none
package aoc_pkg;
  typedef enum logic [2:0] {
    AOC_R_0_10V = 3'h0, AOC_R_0_5V = 3'h1, AOC_R_1_5V = 3'h2,
    AOC_R_0_20MA = 3'h3, AOC_R_4_20MA = 3'h4
  } aoc_range_e;
  typedef enum logic [1:0] {
    AOC_F_OFFSET = 2'h0, AOC_F_SIGNMAG = 2'h1, AOC_F_TWOS = 2'h2,
    AOC_F_SCALED = 2'h3
  } aoc_fmt_e;
  typedef enum logic [2:0] {
    AOC_S_RUN = 3'b001, AOC_S_FAULT = 3'b010, AOC_S_IDLE = 3'b100
  } aoc_mode_e;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } aoc_wb_req_s;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } aoc_wb_rsp_s;
  typedef struct packed {
    logic        comm_err;
    logic        comm_idle;
    logic        short_det;
  } aoc_link_s;
endpackage : aoc_pkg
`default_nettype wire

// ==== design/aoc_scaler.sv ====
`default_nettype none
`include "aoc_params.svh"
// Maps a scaled value onto the range in hundredths, registered output
module aoc_scaler (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  // Operands
  input  wire logic signed [15:0] value,
  input  wire logic signed [15:0] scale_hi,
  input  wire logic signed [15:0] scale_lo,
  input  wire logic signed [15:0] end_lo,
  input  wire logic signed [15:0] end_hi,
  // Result
  output logic signed [15:0]      phys
);
  logic signed [17:0] dv;
  logic signed [17:0] ds;
  logic signed [35:0] prod;
  logic signed [35:0] quo;
  logic signed [35:0] sum;
  logic signed [15:0] phys_reg;
  logic signed [15:0] phys_next;
  always_comb begin
    dv        = 18'(value) - 18'(scale_lo);
    ds        = 18'(scale_hi) - 18'(scale_lo);
    prod      = 36'(dv) * 36'(18'(end_hi) - 18'(end_lo));
    // Zero span would divide by zero; pin to the low end instead
    quo       = (ds == 18'sh0) ? 36'sh0 : prod / 36'(ds);
    sum       = quo + 36'(end_lo);
    phys_next = sum[15:0];
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phys_reg <= 16'sh0000;
    end else begin
      phys_reg <= phys_next;
    end
  end
  assign phys = phys_reg;
endmodule : aoc_scaler
`default_nettype wire

// ==== design/aoc_top.sv ====
// Design decisions made here: the register offsets and the Wishbone slave port.
`default_nettype none
`include "aoc_params.svh"
// Behaviour
// - Scaled format maps the range linearly onto a span within +-32767.
// - Scale limits are clamped to their legal spans, reset 1000 and 0.
// - A 16-bit limit with top bit set means minus its low 15 bits.
// - Short-circuit error is raised only while detection is enabled.
// - Each channel selects one of five ranges, reset 0-10 V.
// - Four unit-wide data formats, offset binary at reset.
// - Upper check enabled flags an error when output exceeds upper limit.
// - Lower check enabled flags an error when output is below lower limit.
// - On communication error drive the fault value if enabled, else hold.
// - During idle drive the idle value if enabled, else hold.
// - Fault and idle choices apply only under software fail control.
module aoc_top
  import aoc_pkg::*;
(
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           rst_n,
  // Wishbone slave
  input  wire aoc_pkg::aoc_wb_req_s wb_req,
  output aoc_pkg::aoc_wb_rsp_s      wb_rsp,
  // Link and pin status, asynchronous
  input  wire aoc_pkg::aoc_link_s   link_in,
  // Analogue output code, in hundredths of V or mA in scaled format, else the output word
  output logic [15:0]         ao_value,
  output logic                err_short,
  output logic                err_upper,
  output logic                err_lower
);
  import aoc_pkg::*;

  typedef struct packed {
    logic              ack;
    logic [31:0]       rdat;
    logic              sc_en;
    aoc_fmt_e          fmt;
    logic              swctl;
    aoc_range_e        range;
    logic              ul_en;
    logic              ll_en;
    logic              fault_en;
    logic              idle_en;
    logic signed [15:0] scale_hi;
    logic signed [15:0] scale_lo;
    logic signed [15:0] fault_v;
    logic signed [15:0] idle_v;
    logic signed [15:0] cmd;
    logic signed [15:0] out;
    aoc_mode_e         mode;
    aoc_link_s         sync1;
    aoc_link_s         sync2;
    logic              e_short;
    logic              e_up;
    logic              e_lo;
    logic [15:0]       ao;
  } aoc_state_s;

  aoc_state_s st_reg;
  aoc_state_s st_next;
  logic signed [15:0] phys;
  logic signed [15:0] end_lo;
  logic signed [15:0] end_hi;
  logic signed [15:0] wval;
  logic signed [15:0] limv;
  logic               wr;

  // Sign-magnitude limit code to two's complement
  function automatic logic signed [15:0] aoc_sm2s(input logic [15:0] c);
    logic signed [15:0] m;
    m = {1'b0, c[14:0]};
    return c[15] ? -m : m;
  endfunction : aoc_sm2s

  always_comb begin
    case (st_reg.range)
      AOC_R_0_5V: begin
        end_lo = `AOC_END_0V;
        end_hi = `AOC_END_5V;
      end
      AOC_R_1_5V: begin
        end_lo = `AOC_END_1V;
        end_hi = `AOC_END_5V;
      end
      AOC_R_0_20MA: begin
        end_lo = `AOC_END_0V;
        end_hi = `AOC_END_20MA;
      end
      AOC_R_4_20MA: begin
        end_lo = `AOC_END_4MA;
        end_hi = `AOC_END_20MA;
      end
      default: begin
        end_lo = `AOC_END_0V;
        end_hi = `AOC_END_10V;
      end
    endcase
  end

  aoc_scaler u_scaler (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .value    (st_reg.out),
    .scale_hi (st_reg.scale_hi),
    .scale_lo (st_reg.scale_lo),
    .end_lo   (end_lo),
    .end_hi   (end_hi),
    .phys     (phys)
  );

  always_comb begin
    st_next = st_reg;
    // Write lands at the edge where the master sees ack high
    wr   = wb_req.cyc && wb_req.stb && wb_req.we && st_reg.ack &&
           (&wb_req.sel);
    wval = wb_req.dat[15:0];
    limv = aoc_sm2s(wb_req.dat[15:0]);
    st_next.ack = wb_req.cyc && wb_req.stb && !st_reg.ack;
    st_next.sync1 = link_in;
    st_next.sync2 = st_reg.sync1;
    if (wr) begin
      case (wb_req.adr)
        `AOC_ADDR_UNIT: begin
          st_next.sc_en = wb_req.dat[`AOC_UNIT_SC_EN];
          st_next.fmt   = aoc_fmt_e'(wb_req.dat[`AOC_UNIT_FMT_LSB +: 2]);
          st_next.swctl = wb_req.dat[`AOC_UNIT_SWCTL];
        end
        `AOC_ADDR_CHCFG: begin
          if (wb_req.dat[`AOC_CH_RANGE_LSB +: 3] <= 3'h4) begin
            st_next.range =
              aoc_range_e'(wb_req.dat[`AOC_CH_RANGE_LSB +: 3]);
          end
          st_next.ul_en    = wb_req.dat[`AOC_CH_UL_EN];
          st_next.ll_en    = wb_req.dat[`AOC_CH_LL_EN];
          st_next.fault_en = wb_req.dat[`AOC_CH_FAULT_EN];
          st_next.idle_en  = wb_req.dat[`AOC_CH_IDLE_EN];
        end
        `AOC_ADDR_SCALE_HI: begin
          // Upper limit may not drop to the floor code
          st_next.scale_hi = (limv < -16'sh7ffe) ? -16'sh7ffe : limv;
        end
        `AOC_ADDR_SCALE_LO: begin
          st_next.scale_lo = (limv > 16'sh7ffe) ? 16'sh7ffe : limv;
        end
        `AOC_ADDR_FAULTV: st_next.fault_v = limv;
        `AOC_ADDR_IDLEV:  st_next.idle_v  = limv;
        `AOC_ADDR_CMD: begin
          // -32768 has no scaled meaning, pull it in
          st_next.cmd = (wval == 16'sh8000) ? `AOC_SCALE_MIN : wval;
        end
        default: ;
      endcase
    end
    // Mode selection: error outranks idle
    if (st_reg.sync2.comm_err) begin
      st_next.mode = AOC_S_FAULT;
    end else if (st_reg.sync2.comm_idle) begin
      st_next.mode = AOC_S_IDLE;
    end else begin
      st_next.mode = AOC_S_RUN;
    end
    case (st_reg.mode)
      AOC_S_RUN:   st_next.out = st_next.cmd;
      AOC_S_FAULT: begin
        if (st_reg.swctl && st_reg.fault_en) begin
          st_next.out = st_reg.fault_v;
        end
      end
      AOC_S_IDLE: begin
        if (st_reg.swctl && st_reg.idle_en) begin
          st_next.out = st_reg.idle_v;
        end
      end
      default: st_next.mode = AOC_S_RUN;
    endcase
    st_next.e_short = st_reg.sc_en && st_reg.sync2.short_det;
    st_next.e_up = st_reg.ul_en && (st_reg.out > st_reg.scale_hi);
    st_next.e_lo = st_reg.ll_en && (st_reg.out < st_reg.scale_lo);
    // Scaled format goes through the scaler, others pass the word on
    st_next.ao = (st_reg.fmt == AOC_F_SCALED) ? phys : st_reg.out;
    st_next.rdat = 32'h0;
    case (wb_req.adr)
      `AOC_ADDR_UNIT: begin
        st_next.rdat = {28'h0, st_reg.swctl, st_reg.fmt, st_reg.sc_en};
      end
      `AOC_ADDR_CHCFG: begin
        st_next.rdat = {25'h0, st_reg.idle_en, st_reg.fault_en,
                        st_reg.ll_en, st_reg.ul_en, st_reg.range};
      end
      `AOC_ADDR_SCALE_HI: st_next.rdat = {16'h0, st_reg.scale_hi};
      `AOC_ADDR_SCALE_LO: st_next.rdat = {16'h0, st_reg.scale_lo};
      `AOC_ADDR_FAULTV:   st_next.rdat = {16'h0, st_reg.fault_v};
      `AOC_ADDR_IDLEV:    st_next.rdat = {16'h0, st_reg.idle_v};
      `AOC_ADDR_CMD:      st_next.rdat = {16'h0, st_reg.cmd};
      `AOC_ADDR_OUT:      st_next.rdat = {16'h0, st_reg.out};
      `AOC_ADDR_STATUS: begin
        st_next.rdat = {26'h0, st_reg.mode, st_reg.e_lo, st_reg.e_up,
                        st_reg.e_short};
      end
      default: st_next.rdat = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg          <= '0;
      st_reg.fmt      <= AOC_F_OFFSET;
      st_reg.range    <= AOC_R_0_10V;
      st_reg.scale_hi <= `AOC_SCALE_HI_RST;
      st_reg.scale_lo <= `AOC_SCALE_LO_RST;
      st_reg.mode     <= AOC_S_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ao_value  = st_reg.ao;
  assign err_short = st_reg.e_short;
  assign err_upper = st_reg.e_up;
  assign err_lower = st_reg.e_lo;
  assign wb_rsp    = '{ack: st_reg.ack, dat: st_reg.rdat};

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  short_err_a: assert property (
    $past(st_reg.sc_en) && $past(st_reg.sync2.short_det) |-> err_short)
    else $error("short error missing");
  short_off_a: assert property (
    !$past(st_reg.sc_en) |-> !err_short)
    else $error("short error while disabled");
  upper_chk_a: assert property (
    err_upper |-> $past(st_reg.ul_en) &&
                  ($past(st_reg.out) > $past(st_reg.scale_hi)))
    else $error("upper error without cause");
  lower_chk_a: assert property (
    err_lower |-> $past(st_reg.ll_en) &&
                  ($past(st_reg.out) < $past(st_reg.scale_lo)))
    else $error("lower error without cause");
  scale_span_a: assert property (
    st_reg.scale_hi != 16'sh8001 && st_reg.scale_lo != 16'sh7fff)
    else $error("scale limit out of span");
  cmd_span_a: assert property (
    st_reg.cmd != 16'sh8000)
    else $error("command outside span");
  sequence fault_hold_s;
    st_reg.mode == AOC_S_FAULT && !(st_reg.swctl && st_reg.fault_en);
  endsequence
  fault_hold_a: assert property (
    fault_hold_s |=> $stable(st_reg.out))
    else $error("output moved while holding");
  fault_value_a: assert property (
    st_reg.mode == AOC_S_FAULT && st_reg.swctl && st_reg.fault_en
      |=> st_reg.out == $past(st_reg.fault_v))
    else $error("fault value not driven");
  idle_value_a: assert property (
    st_reg.mode == AOC_S_IDLE && st_reg.swctl && st_reg.idle_en
      |=> st_reg.out == $past(st_reg.idle_v))
    else $error("idle value not driven");
  range_legal_a: assert property (
    st_reg.range <= AOC_R_4_20MA)
    else $error("illegal range code");

  upper_set_a: assert property (
    st_reg.ul_en && (st_reg.out > st_reg.scale_hi) |=> err_upper)
    else $error("upper error missing");
  lower_set_a: assert property (
    st_reg.ll_en && (st_reg.out < st_reg.scale_lo) |=> err_lower)
    else $error("lower error missing");
  sequence idle_hold_s;
    st_reg.mode == AOC_S_IDLE && !(st_reg.swctl && st_reg.idle_en);
  endsequence
  idle_hold_a: assert property (
    idle_hold_s |=> $stable(st_reg.out))
    else $error("output moved while idle holding");
  // Error outranks idle once the synchronised level is in
  fault_mode_a: assert property (
    st_reg.sync2.comm_err |=> st_reg.mode == AOC_S_FAULT)
    else $error("fault mode not entered");
  idle_mode_a: assert property (
    !st_reg.sync2.comm_err && st_reg.sync2.comm_idle
      |=> st_reg.mode == AOC_S_IDLE)
    else $error("idle mode not entered");
  mode_onehot_a: assert property (
    $onehot(st_reg.mode))
    else $error("mode not one-hot");
  scaled_out_a: assert property (
    st_reg.fmt == AOC_F_SCALED |=> ao_value == $past(phys))
    else $error("scaled code not passed on");
  plain_out_a: assert property (
    st_reg.fmt != AOC_F_SCALED |=> ao_value == $past(st_reg.out))
    else $error("output word not passed on");
  // Normal running tracks the command word
  run_out_a: assert property (
    st_reg.mode == AOC_S_RUN |=> st_reg.out == $past(st_next.cmd))
    else $error("output not following command");
  // Ack must not stay high for two cycles in a row
  ack_pulse_a: assert property (
    wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack longer than one cycle");
endmodule : aoc_top
`default_nettype wire

// ==== test/aoc_link_model.sv ====
`default_nettype none
// Far-side link status, changed only just after a clock edge
module aoc_link_model
  import aoc_pkg::*;
(
  // Clock
  input  wire logic       sys_clk,
  // Requested status {error, idle, short}
  input  wire logic [2:0] want,
  // Status towards the block
  output aoc_pkg::aoc_link_s link
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge sys_clk) begin
    link <= want;
  end
endmodule : aoc_link_model
`default_nettype wire

// ==== test/tb.sv ====
`default_nettype none
`include "aoc_params.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
  import aoc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  aoc_wb_req_s req = '0;
  aoc_wb_rsp_s wb_rsp;
  aoc_link_s   link;
  logic [2:0]  want = 3'h0;
  logic [15:0] ao_value;
  logic        err_short, err_upper, err_lower;
  logic [31:0] exp_q[$];
  logic [31:0] exp_rd;
  integer      n_mismatch = 0;
  integer      compares = 0;
  integer      seed = 32'h90865443;
  integer      k, j;
  always #10 sys_clk = ~sys_clk;
  aoc_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_req(req),
    .wb_rsp(wb_rsp), .link_in(link), .ao_value(ao_value),
    .err_short(err_short), .err_upper(err_upper), .err_lower(err_lower));
  aoc_link_model far (.sys_clk(sys_clk), .want(want), .link(link));
  task end_of_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // Read data is judged by the monitor as soon as ack shows
  always @(posedge sys_clk) begin
    if (wb_rsp.ack === 1'b1 && req.we === 1'b0 && req.cyc === 1'b1) begin
      exp_rd = exp_q.pop_front();
      `CHK("read data", exp_rd, wb_rsp.dat)
    end
  end
  task wb(input logic we, input logic [7:0] a, input logic [15:0] d);
    integer i;
    @(posedge sys_clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf,
             dat: {16'h0, d}};
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (wb_rsp.ack !== 1'b1 && i < 20);
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      end_of_test;
    end
  endtask : wb
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 16'h0);
  endtask : rd
  // Bounded wait for {short, upper, lower, output code}
  task wait_out(input logic [18:0] e);
    integer i;
    for (i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      if ({err_short, err_upper, err_lower, ao_value} === e) break;
    end
    `CHK("outputs", e, {err_short, err_upper, err_lower, ao_value})
    if (i == 40) end_of_test;
  endtask : wait_out
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`AOC_ADDR_UNIT, 32'h0);
    rd(`AOC_ADDR_CHCFG, 32'h0);
    rd(`AOC_ADDR_SCALE_HI, 32'h3e8);
    rd(`AOC_ADDR_SCALE_LO, 32'h0);
    rd(`AOC_ADDR_STATUS, 32'h8);
    wb(1'b1, `AOC_ADDR_SCALE_HI, 16'hffff);
    rd(`AOC_ADDR_SCALE_HI, 32'h8002);
    wb(1'b1, `AOC_ADDR_SCALE_LO, 16'h8005);
    rd(`AOC_ADDR_SCALE_LO, 32'hfffb);
    wb(1'b1, `AOC_ADDR_SCALE_LO, 16'h7fff);
    rd(`AOC_ADDR_SCALE_LO, 32'h7ffe);
    wb(1'b1, 8'h24, 16'h1234);
    rd(8'h24, 32'h0);
    wb(1'b1, `AOC_ADDR_SCALE_HI, 16'h03e8);
    wb(1'b1, `AOC_ADDR_SCALE_LO, 16'h0000);
    // Both limit checks on
    wb(1'b1, `AOC_ADDR_CHCFG, 16'h0018);
    wb(1'b1, `AOC_ADDR_CMD, 16'h03e9);
    wait_out({3'b010, 16'h03e9});
    rd(`AOC_ADDR_STATUS, 32'ha);
    wb(1'b1, `AOC_ADDR_CMD, 16'hffff);
    wait_out({3'b001, 16'hffff});
    wb(1'b1, `AOC_ADDR_CHCFG, 16'h0000);
    wait_out({3'b000, 16'hffff});
    want <= 3'b001;
    wb(1'b1, `AOC_ADDR_UNIT, 16'h0001);
    wait_out({3'b100, 16'hffff});
    wb(1'b1, `AOC_ADDR_UNIT, 16'h0000);
    wait_out({3'b000, 16'hffff});
    want <= 3'b000;
    // Fault and idle values under software fail control
    wb(1'b1, `AOC_ADDR_CMD, 16'd200);
    wb(1'b1, `AOC_ADDR_FAULTV, 16'd500);
    wb(1'b1, `AOC_ADDR_IDLEV, 16'd300);
    wb(1'b1, `AOC_ADDR_CHCFG, 16'h0060);
    wb(1'b1, `AOC_ADDR_UNIT, 16'h0008);
    want <= 3'b100;
    wait_out({3'b000, 16'd500});
    rd(`AOC_ADDR_STATUS, 32'h10);
    want <= 3'b110;
    repeat (6) @(posedge sys_clk);
    wait_out({3'b000, 16'd500});
    want <= 3'b010;
    wait_out({3'b000, 16'd300});
    want <= 3'b000;
    wait_out({3'b000, 16'd200});
    // Without software control the last output is held
    wb(1'b1, `AOC_ADDR_UNIT, 16'h0000);
    want <= 3'b100;
    repeat (6) @(posedge sys_clk);
    wait_out({3'b000, 16'd200});
    want <= 3'b010;
    repeat (6) @(posedge sys_clk);
    wait_out({3'b000, 16'd200});
    want <= 3'b000;
    // Scaled, 1-5 V over 1000..5000; limits refitted after range change
    wb(1'b1, `AOC_ADDR_CHCFG, 16'h0002);
    wb(1'b1, `AOC_ADDR_SCALE_HI, 16'd5000);
    wb(1'b1, `AOC_ADDR_SCALE_LO, 16'd1000);
    wb(1'b1, `AOC_ADDR_UNIT, 16'h0006);
    for (j = 0; j < 6; j++) begin
      k = (j == 0) ? 0 : (j == 1) ? 400 : $unsigned($random(seed)) % 401;
      wb(1'b1, `AOC_ADDR_CMD, 16'(1000 + 10 * k));
      wait_out({3'b000, 16'(100 + k)});
    end
    // Middle of the scale span lands mid-range in every range
    wb(1'b1, `AOC_ADDR_CMD, 16'd3000);
    for (j = 0; j < 5; j++) begin
      case (j)
        0: k = (`AOC_END_0V + `AOC_END_10V) / 2;
        1: k = (`AOC_END_0V + `AOC_END_5V) / 2;
        2: k = (`AOC_END_1V + `AOC_END_5V) / 2;
        3: k = (`AOC_END_0V + `AOC_END_20MA) / 2;
        default: k = (`AOC_END_4MA + `AOC_END_20MA) / 2;
      endcase
      wb(1'b1, `AOC_ADDR_CHCFG, 16'(j));
      wait_out({3'b000, 16'(k)});
    end
    // Range codes above the last one leave the range alone
    wb(1'b1, `AOC_ADDR_CHCFG, 16'h0007);
    rd(`AOC_ADDR_CHCFG, 32'h4);
    rd(`AOC_ADDR_OUT, 32'hbb8);
    wb(1'b1, `AOC_ADDR_CMD, 16'h8000);
    rd(`AOC_ADDR_CMD, 32'h8001);
    wb(1'b1, `AOC_ADDR_UNIT, 16'h0002);
    rd(`AOC_ADDR_UNIT, 32'h2);
    // Reset in mid-run brings back the defaults
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`AOC_ADDR_UNIT, 32'h0);
    rd(`AOC_ADDR_CHCFG, 32'h0);
    rd(`AOC_ADDR_SCALE_HI, 32'h3e8);
    wait_out({3'b000, 16'h0000});
    end_of_test;
  end
endmodule : tb
`default_nettype wire
